// >>> rtl/prl_ctrl_pkg.sv
// shared constants, state types and timing helpers for the protocol reset and test controller
package prl_ctrl_pkg;

    // =========================================================
    // clock and widths
    localparam int CLK_PERIOD_NS = 100;
    localparam int MSG_ID_W      = 3;
    localparam int ERR_W         = 16;
    localparam int BDO_W         = 32;
    localparam int MODE_W        = 4;
    localparam int MODE_LSB      = 28;
    localparam int TMR_W         = 24;

    // =========================================================
    // reset values
    localparam logic [MSG_ID_W-1:0] MSG_ID_RESET = 3'h0;
    localparam logic [ERR_W-1:0]    ERR_RESET    = 16'h0000;
    localparam logic [BDO_W-1:0]    BDO_RESET    = 32'h0000_0000;
    localparam logic [TMR_W-1:0]    TMR_ZERO     = 24'h00_0000;
    localparam logic [TMR_W-1:0]    TMR_ONE      = 24'h00_0001;
    localparam logic [MSG_ID_W-1:0] MSG_ID_ONE   = 3'h1;

    // =========================================================
    // state types
    typedef enum logic [2:0] {
        HR_IDLE, HR_LAYER, HR_IND, HR_REQ,
        HR_WAIT_PHY, HR_PHY_REQD, HR_WAIT_PE, HR_PE_DONE
    } hr_state_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_INIT, TX_WAIT, TX_FRAME, TX_RESP
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_CLEAR, RX_FRAME, RX_COUNT, RX_INFORM
    } rx_state_t;

    // =========================================================
    // least time in ns to whole clock cycles, never below one
    function automatic int cycles_up(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cycles_up

endpackage : prl_ctrl_pkg

// >>> rtl/prl_reset_bist_ctrl.sv
// protocol layer reset sequencer with test transmitter and receiver sequencers
// What this block does
// - any hard reset request or signaling, a cable reset request, or cable reset signaling while is_cable_plug is set enters the reset-layer state
// - reset-layer entry clears message id and forces tx and rx machines idle
// - during hard reset no messages pass; channel stays disabled until done
// - during cable reset plug messages stop, other traffic may continue
// - layer reset done and request came from policy: go to request-reset
// - layer reset done and signaling came from phy: go to indicate-reset
// - indicate-reset tells policy engine, then waits policy completion
// - request-reset asks phy for signaling, then waits phy completion
// - wait-phy-completion starts the reset completion timer
// - leave wait-phy on hard done, cable done or timer expiry
// - phy-reset-requested informs policy engine, then waits policy completion
// - policy engine completion moves to policy-complete state
// - policy-complete tells phy reset is done, then returns to normal
// - on hard reset exit pending hard reset signaling is cancelled
// - tx idle plus policy test request enters test transmit init
// - test init asks phy to clear counter and preload, waits for preload
// - test frame request asks phy to build frame, then awaits response
// - response state starts the test response timer
// - count response or timeout returns to wait and reports it
// - rx idle plus policy receive test request clears counter and preloads
// - receive frame state waits for phy error count
// - count state sends test message with returned counters object
// - inform state tells policy count was sent, back to frame state
// - receive test mode leaves only through the reset sequence
`timescale 1ns/1ps
module prl_reset_bist_ctrl
    import prl_ctrl_pkg::*;
#(
    parameter int                 RESET_DONE_NS = 5_000_000,
    parameter int                 BIST_RESP_NS  = 1_000_000,
    parameter logic [MODE_W-1:0]  RET_CNT_MODE  = 4'h1      // arbitrary mode code
) (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic                          clk_en,
    input  wire logic                          is_cable_plug,
    input  wire logic                          pe_hard_reset_req,
    input  wire logic                          pe_cable_reset_req,
    input  wire logic                          phy_hard_reset_sig,
    input  wire logic                          phy_cable_reset_sig,
    input  wire logic                          phy_reset_complete,
    input  wire logic                          pe_reset_complete,
    input  wire logic                          msg_id_inc,
    input  wire logic                          pe_bist_tx_req,
    input  wire logic                          pe_test_frame_req,
    input  wire logic                          pe_bist_rx_req,
    input  wire logic                          phy_bist_prep_done,
    input  wire logic                          phy_err_count_valid,
    input  wire logic [prl_ctrl_pkg::ERR_W-1:0] phy_err_count,
    input  wire logic                          phy_msg_sent,
    output logic [prl_ctrl_pkg::MSG_ID_W-1:0]  message_id_counter_a,
    output logic                               tx_idle_force,
    output logic                               rx_idle_force,
    output logic                               hard_block,
    output logic                               cable_block,
    output logic                               reset_is_hard,
    output logic                               pe_reset_ind,
    output logic                               phy_reset_req,
    output logic                               pe_phy_reset_reqd,
    output logic                               phy_reset_done,
    output logic                               phy_cancel_pending,
    output logic                               phy_bist_prep_req,
    output logic                               phy_test_frame_req,
    output logic                               pe_err_count_rpt,
    output logic                               pe_bist_timeout,
    output logic [prl_ctrl_pkg::ERR_W-1:0]     err_count,
    output logic                               phy_bist_msg_req,
    output logic [prl_ctrl_pkg::BDO_W-1:0]     test_data_object,
    output logic                               pe_count_sent
);
    import prl_ctrl_pkg::*;

    // =========================================================
    // timing
    localparam logic [TMR_W-1:0] HR_CYC   = TMR_W'(cycles_up(RESET_DONE_NS));
    localparam logic [TMR_W-1:0] BIST_CYC = TMR_W'(cycles_up(BIST_RESP_NS));

    // =========================================================
    // reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // two stage release of the async reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else if (clk_en) begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // =========================================================
    // state and registers
    hr_state_t            hr_q, hr_d;
    tx_state_t            tx_q, tx_d;
    rx_state_t            rx_q, rx_d;
    logic                 from_pe_q, hard_q;
    logic [TMR_W-1:0]     hr_tmr_q, bist_tmr_q;
    logic [MSG_ID_W-1:0]  msg_id_q;
    logic [ERR_W-1:0]     err_q;
    logic [BDO_W-1:0]     tdo_q;
    logic tx_force_q, rx_force_q, hard_blk_q, cable_blk_q;
    logic ind_q, req_q, reqd_q, done_q, cancel_q;
    logic prep_q, frame_q, rpt_q, tmo_q, bmsg_q, sent_q;

    // =========================================================
    // event decode
    wire rst_ev    = pe_hard_reset_req | phy_hard_reset_sig | pe_cable_reset_req
                   | (phy_cable_reset_sig & is_cable_plug);
    wire ev_hard   = pe_hard_reset_req | phy_hard_reset_sig;
    wire ev_pe     = pe_hard_reset_req | pe_cable_reset_req;
    wire hr_quiet  = (hr_q == HR_IDLE);
    wire hr_tmr_ex = (hr_tmr_q == TMR_ZERO);
    wire bist_ex   = (bist_tmr_q == TMR_ZERO);
    wire hr_enter_wait = (hr_d == HR_WAIT_PHY) && (hr_q != HR_WAIT_PHY);
    wire tx_enter_resp = (tx_d == TX_RESP) && (tx_q != TX_RESP);
    wire tx_enter_init = (tx_d == TX_INIT) && (tx_q != TX_INIT);
    wire rx_enter_clr  = (rx_d == RX_CLEAR) && (rx_q != RX_CLEAR);
    wire rx_enter_cnt  = (rx_d == RX_COUNT) && (rx_q != RX_COUNT);
    wire tx_resp_exit  = (tx_q == TX_RESP) && (tx_d == TX_WAIT);
    wire kind_hard     = rst_ev ? ev_hard : hard_q;
    wire cnt_capture   = phy_err_count_valid
                       && (((tx_q == TX_RESP) && !rst_ev) || ((rx_q == RX_FRAME) && !rst_ev));

    // =========================================================
    // reset sequence next state
    always_comb begin
        hr_d = hr_q;
        if (rst_ev) begin
            hr_d = HR_LAYER;
        end else begin
            unique case (hr_q)
                HR_IDLE:     hr_d = HR_IDLE;
                HR_LAYER:    hr_d = from_pe_q ? HR_REQ : HR_IND;
                HR_IND:      hr_d = HR_WAIT_PE;
                HR_REQ:      hr_d = HR_WAIT_PHY;
                HR_WAIT_PHY: begin
                    if (phy_reset_complete || hr_tmr_ex) begin
                        hr_d = HR_PHY_REQD;
                    end
                end
                HR_PHY_REQD: hr_d = HR_WAIT_PE;
                HR_WAIT_PE: begin
                    if (pe_reset_complete) begin
                        hr_d = HR_PE_DONE;
                    end
                end
                HR_PE_DONE:  hr_d = HR_IDLE;
            endcase
        end
    end

    // =========================================================
    // test transmitter next state
    always_comb begin
        tx_d = tx_q;
        if (rst_ev) begin
            tx_d = TX_IDLE;
        end else begin
            unique case (tx_q)
                TX_IDLE: begin
                    if (pe_bist_tx_req && hr_quiet) begin
                        tx_d = TX_INIT;
                    end
                end
                TX_INIT: begin
                    if (phy_bist_prep_done) begin
                        tx_d = TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (pe_test_frame_req) begin
                        tx_d = TX_FRAME;
                    end
                end
                TX_FRAME: tx_d = TX_RESP;
                TX_RESP: begin
                    if (phy_err_count_valid || bist_ex) begin
                        tx_d = TX_WAIT;
                    end
                end
                default: tx_d = TX_IDLE;
            endcase
        end
    end

    // =========================================================
    // test receiver next state, left only by a reset event
    always_comb begin
        rx_d = rx_q;
        if (rst_ev) begin
            rx_d = RX_IDLE;
        end else begin
            unique case (rx_q)
                RX_IDLE: begin
                    if (pe_bist_rx_req && hr_quiet) begin
                        rx_d = RX_CLEAR;
                    end
                end
                RX_CLEAR: begin
                    if (phy_bist_prep_done) begin
                        rx_d = RX_FRAME;
                    end
                end
                RX_FRAME: begin
                    if (phy_err_count_valid) begin
                        rx_d = RX_COUNT;
                    end
                end
                RX_COUNT: begin
                    if (phy_msg_sent) begin
                        rx_d = RX_INFORM;
                    end
                end
                RX_INFORM: rx_d = RX_FRAME;
                default:   rx_d = RX_IDLE;
            endcase
        end
    end

    // =========================================================
    // state registers and reset origin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hr_q      <= HR_IDLE;
            tx_q      <= TX_IDLE;
            rx_q      <= RX_IDLE;
            from_pe_q <= 1'b0;
            hard_q    <= 1'b0;
        end else if (clk_en) begin
            hr_q      <= hr_d;
            tx_q      <= tx_d;
            rx_q      <= rx_d;
            from_pe_q <= rst_ev ? ev_pe : from_pe_q;
            hard_q    <= kind_hard;
        end
    end

    // =========================================================
    // reset completion and test response timers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hr_tmr_q   <= TMR_ZERO;
            bist_tmr_q <= TMR_ZERO;
        end else if (clk_en) begin
            hr_tmr_q   <= hr_enter_wait ? HR_CYC - TMR_ONE
                        : (hr_tmr_ex ? hr_tmr_q : hr_tmr_q - TMR_ONE);
            bist_tmr_q <= tx_enter_resp ? BIST_CYC - TMR_ONE
                        : (bist_ex ? bist_tmr_q : bist_tmr_q - TMR_ONE);
        end
    end

    // =========================================================
    // message id counter, cleared by every reset event
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            msg_id_q <= MSG_ID_RESET;
        end else if (clk_en) begin
            if (rst_ev) begin
                msg_id_q <= MSG_ID_RESET;
            end else if (msg_id_inc) begin
                msg_id_q <= msg_id_q + MSG_ID_ONE;
            end
        end
    end

    // =========================================================
    // reset sequence indications, one cycle each except hard and cable block held through the sequence
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_force_q  <= 1'b0;
            rx_force_q  <= 1'b0;
            hard_blk_q  <= 1'b0;
            cable_blk_q <= 1'b0;
            ind_q       <= 1'b0;
            req_q       <= 1'b0;
            reqd_q      <= 1'b0;
            done_q      <= 1'b0;
            cancel_q    <= 1'b0;
        end else if (clk_en) begin
            tx_force_q  <= rst_ev;
            rx_force_q  <= rst_ev;
            hard_blk_q  <= (hr_d != HR_IDLE) && kind_hard;
            cable_blk_q <= (hr_d != HR_IDLE) && !kind_hard;
            ind_q       <= hr_d == HR_IND;
            req_q       <= hr_d == HR_REQ;
            reqd_q      <= hr_d == HR_PHY_REQD;
            done_q      <= hr_d == HR_PE_DONE;
            cancel_q    <= (hr_d == HR_PE_DONE) && kind_hard;
        end
    end

    // =========================================================
    // test sequencer indications and captured count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prep_q  <= 1'b0;
            frame_q <= 1'b0;
            rpt_q   <= 1'b0;
            tmo_q   <= 1'b0;
            bmsg_q  <= 1'b0;
            sent_q  <= 1'b0;
            err_q   <= ERR_RESET;
            tdo_q   <= BDO_RESET;
        end else if (clk_en) begin
            prep_q  <= tx_enter_init || rx_enter_clr;
            frame_q <= tx_d == TX_FRAME;
            rpt_q   <= tx_resp_exit && phy_err_count_valid;
            tmo_q   <= tx_resp_exit && !phy_err_count_valid;
            bmsg_q  <= rx_enter_cnt;
            sent_q  <= rx_d == RX_INFORM;
            err_q   <= cnt_capture ? phy_err_count : err_q;
            if (rx_enter_cnt) begin
                tdo_q <= {RET_CNT_MODE, (MODE_LSB - ERR_W)'(0), phy_err_count};
            end
        end
    end

    // =========================================================
    // outputs straight from registers
    assign message_id_counter_a = msg_id_q;
    assign tx_idle_force        = tx_force_q;
    assign rx_idle_force        = rx_force_q;
    assign hard_block           = hard_blk_q;
    assign cable_block          = cable_blk_q;
    assign reset_is_hard        = hard_q;
    assign pe_reset_ind         = ind_q;
    assign phy_reset_req        = req_q;
    assign pe_phy_reset_reqd    = reqd_q;
    assign phy_reset_done       = done_q;
    assign phy_cancel_pending   = cancel_q;
    assign phy_bist_prep_req    = prep_q;
    assign phy_test_frame_req   = frame_q;
    assign pe_err_count_rpt     = rpt_q;
    assign pe_bist_timeout      = tmo_q;
    assign err_count            = err_q;
    assign phy_bist_msg_req     = bmsg_q;
    assign test_data_object     = tdo_q;
    assign pe_count_sent        = sent_q;

    // =========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_layer_done_pe;
        (hr_q == HR_LAYER) && from_pe_q && clk_en && !rst_ev;
    endsequence

    sequence s_rx_in_test;
        (rx_q != RX_IDLE) && clk_en;
    endsequence

    a_reset_clears_id: assert property (rst_ev && clk_en |=> msg_id_q == MSG_ID_RESET && tx_force_q && rx_force_q)
        else $error("reset event did not clear id or force idle");
    a_hard_blocks_msgs: assert property (rst_ev && ev_hard && clk_en |=> hard_blk_q && !cable_blk_q)
        else $error("hard reset not blocking messages");
    a_pe_path_request: assert property (s_layer_done_pe |=> req_q && hr_q == HR_REQ)
        else $error("policy reset did not request phy signaling");
    a_phy_path_ind: assert property ((hr_q == HR_LAYER) && !from_pe_q && clk_en && !rst_ev
        |=> ind_q ##0 (!clk_en || rst_ev || hr_d == HR_WAIT_PE))
        else $error("phy reset not indicated to policy");
    a_timer_expiry: assert property ((hr_q == HR_WAIT_PHY) && hr_tmr_ex && clk_en && !rst_ev
        |=> reqd_q && hr_q == HR_PHY_REQD)
        else $error("completion timeout did not advance");
    a_timer_length: assert property (hr_enter_wait && clk_en |=> hr_tmr_q == HR_CYC - TMR_ONE)
        else $error("completion timer wrong load");
    a_pe_complete: assert property ((hr_q == HR_WAIT_PE) && pe_reset_complete && clk_en && !rst_ev
        |=> done_q && (cancel_q == hard_q))
        else $error("policy completion not passed to phy");
    a_tx_timeout_rpt: assert property ((tx_q == TX_RESP) && bist_ex && !phy_err_count_valid && clk_en && !rst_ev
        |=> tmo_q && !rpt_q && tx_q == TX_WAIT)
        else $error("test response timeout not reported");
    a_rx_count_msg: assert property ((rx_q == RX_FRAME) && phy_err_count_valid && clk_en && !rst_ev
        |=> bmsg_q && tdo_q[ERR_W-1:0] == $past(phy_err_count))
        else $error("count message not built from phy count");
    a_rx_no_exit: assert property (s_rx_in_test ##1 (rx_q == RX_IDLE) |-> $past(rst_ev))
        else $error("receive test left without reset");

endmodule : prl_reset_bist_ctrl

// >>> tb/phy_partner.sv
// physical layer model answering the controller's requests
`timescale 1ns/1ps
module phy_partner #(
    parameter logic [15:0] CNT = 16'h00a5
) (
    input  wire logic        mclk,
    input  wire logic        resp_en,
    input  wire logic        frame_go,
    input  wire logic        phy_reset_req,
    input  wire logic        phy_bist_prep_req,
    input  wire logic        phy_test_frame_req,
    input  wire logic        phy_bist_msg_req,
    output logic             phy_reset_complete,
    output logic             phy_bist_prep_done,
    output logic             phy_err_count_valid,
    output logic [15:0]      phy_err_count,
    output logic             phy_msg_sent
);
    logic [2:0] rst_q = 3'h0, prep_q = 3'h0, frm_q = 3'h0, msg_q = 3'h0;
    // three-cycle answers; resp_en low models a stalled channel
    always_ff @(posedge mclk) begin
        rst_q  <= {rst_q[1:0], phy_reset_req & resp_en};
        prep_q <= {prep_q[1:0], phy_bist_prep_req};
        frm_q  <= {frm_q[1:0], (phy_test_frame_req & resp_en) | frame_go};
        msg_q  <= {msg_q[1:0], phy_bist_msg_req};
    end
    assign phy_reset_complete  = rst_q[2];
    assign phy_bist_prep_done  = prep_q[2];
    assign phy_err_count_valid = frm_q[2];
    assign phy_err_count       = frm_q[2] ? CNT : ~CNT; // junk outside valid
    assign phy_msg_sent        = msg_q[2];
endmodule : phy_partner

// >>> tb/test_prl_reset_bist_ctrl.sv
// self-checking bench for the reset and test sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
`define WAITS(s) begin n = 0; while ((s) !== 1'b1 && n < 60) begin @(negedge mclk); n++; end \
    if ((s) !== 1'b1) begin err_total++; $display("CHECK FAILED t=%0t wait ran out", $time); close_out; end end
`define PULSE(s) begin s = 1'b1; @(negedge mclk); s = 1'b0; end
module test_prl_reset_bist_ctrl;
    import prl_ctrl_pkg::*;
    localparam logic [ERR_W-1:0]  CNT  = 16'h00a5;
    localparam logic [MODE_W-1:0] MODE = 4'h3; // arbitrary mode code
    logic mclk = 0, nrst = 0, clk_en = 1, is_cable_plug = 0, resp_en = 1, frame_go = 0;
    logic pe_hard_reset_req = 0, pe_cable_reset_req = 0, phy_hard_reset_sig = 0, phy_cable_reset_sig = 0;
    logic pe_reset_complete = 0, msg_id_inc = 0, pe_bist_tx_req = 0, pe_test_frame_req = 0, pe_bist_rx_req = 0;
    logic phy_reset_complete, phy_bist_prep_done, phy_err_count_valid, phy_msg_sent;
    logic [ERR_W-1:0]    phy_err_count, err_count;
    logic [MSG_ID_W-1:0] message_id_counter_a;
    logic [BDO_W-1:0]    test_data_object;
    logic tx_idle_force, rx_idle_force, hard_block, cable_block, reset_is_hard, pe_reset_ind, phy_reset_req;
    logic pe_phy_reset_reqd, phy_reset_done, phy_cancel_pending, phy_bist_prep_req, phy_test_frame_req;
    logic pe_err_count_rpt, pe_bist_timeout, phy_bist_msg_req, pe_count_sent;
    int   err_total = 0, samples_checked = 0, n;

    prl_reset_bist_ctrl #(.RESET_DONE_NS(2000), .BIST_RESP_NS(1000), .RET_CNT_MODE(MODE)) u_dut (.*);
    phy_partner #(.CNT(CNT)) u_phy (.*);

    initial forever #50 mclk = ~mclk;

    task close_out;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // policy completion held until the phy is told, then block drops
    task finish_reset(input logic hard);
        pe_reset_complete = 1'b1;
        `WAITS(phy_reset_done)
        pe_reset_complete = 1'b0;
        `CHK(phy_cancel_pending, hard)
        repeat (2) @(negedge mclk);
        `CHK(hard_block | cable_block, 1'b0)
    endtask : finish_reset

    task frame_req;
        pe_test_frame_req = 1'b1;
        `WAITS(phy_test_frame_req)
        pe_test_frame_req = 1'b0;
    endtask : frame_req

    task t_pe_hard;
        // two enabled edges with the increment held high
        msg_id_inc = 1'b1;
        repeat (2) @(negedge mclk);
        msg_id_inc = 1'b0;
        `CHK(message_id_counter_a, 3'h2)
        // a reset request seen while the clock enable is low must not act
        clk_en = 1'b0;
        `PULSE(pe_hard_reset_req)
        `CHK(message_id_counter_a, 3'h2)
        clk_en = 1'b1;
        @(negedge mclk);
        `PULSE(pe_hard_reset_req)
        `CHK({tx_idle_force, rx_idle_force, hard_block}, 3'h7)
        `CHK(message_id_counter_a, 3'h0)
        `WAITS(phy_reset_req)
        `CHK(reset_is_hard, 1'b1)
        `WAITS(pe_phy_reset_reqd)
        `CHK(hard_block, 1'b1)
        finish_reset(1'b1);
    endtask : t_pe_hard

    task t_phy_cable;
        `PULSE(phy_cable_reset_sig)
        repeat (2) @(negedge mclk);
        `CHK(cable_block, 1'b0)
        is_cable_plug = 1'b1;
        `PULSE(phy_cable_reset_sig)
        `CHK(cable_block, 1'b1)
        `WAITS(pe_reset_ind)
        `CHK({reset_is_hard, hard_block}, 2'h0)
        finish_reset(1'b0);
        is_cable_plug = 1'b0;
    endtask : t_phy_cable

    task t_timer;
        resp_en = 1'b0;
        `PULSE(pe_cable_reset_req)
        `WAITS(phy_reset_req)
        @(negedge mclk);
        `WAITS(pe_phy_reset_reqd)
        `CHK(n inside {[18:24]}, 1'b1)
        resp_en = 1'b1;
        finish_reset(1'b0);
    endtask : t_timer

    task t_bist_tx;
        `PULSE(pe_bist_tx_req)
        `WAITS(phy_bist_prep_req)
        `WAITS(phy_bist_prep_done)
        @(negedge mclk);
        frame_req;
        `WAITS(pe_err_count_rpt)
        `CHK(err_count, CNT)
        resp_en = 1'b0;
        frame_req;
        `WAITS(pe_bist_timeout)
        `CHK(n inside {[8:13]}, 1'b1)
        resp_en = 1'b1;
    endtask : t_bist_tx

    task t_bist_rx;
        `PULSE(pe_bist_rx_req)
        `WAITS(phy_bist_prep_req)
        repeat (5) @(negedge mclk);
        for (int i = 0; i < 2; i++) begin
            `PULSE(frame_go)
            `WAITS(phy_bist_msg_req)
            `CHK(test_data_object, {MODE, 12'h000, CNT})
            `WAITS(pe_count_sent)
        end
        `PULSE(phy_hard_reset_sig)
        `CHK(rx_idle_force, 1'b1)
        `WAITS(pe_reset_ind)
        finish_reset(1'b1);
    endtask : t_bist_rx

    initial begin
        repeat (6) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        t_pe_hard;
        t_phy_cable;
        t_timer;
        t_bist_tx;
        t_bist_rx;
        close_out;
    end
endmodule : test_prl_reset_bist_ctrl
